// *** rtl/ecw_pkg.sv ***
// Constants, types and timing figures for the page-cache write path of a serial EEPROM.
// Assumes a single 20 MHz core clock; the bus clock and data lines are sampled as plain inputs.
package ecw_pkg;
  localparam int unsigned CACHE_BYTES = 64;
  localparam int unsigned CACHE_PAGES = 8;
  localparam int unsigned PAGE_BYTES = 8;
  localparam int unsigned PTR_W = 6;
  localparam int unsigned PAGE_W = 3;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIFO_WIDTH = ADDR_W + BYTE_W;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam logic [3:0] CTRL_CODE = 4'ha;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;
  localparam logic [PAGE_W-1:0] LAST_BYTE = 3'h7;
  // Page programming interval and its cycle count at the core clock rate
  localparam int unsigned CLK_FREQ_HZ = 20000000;
  localparam int unsigned PAGE_PROG_TIME_MS = 5;
  localparam int unsigned PAGE_PROG_CYCLES_DFLT = PAGE_PROG_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned TIMER_W = 17;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CTRL = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_DATA = 3'b100,
    ST_PUSH = 3'b101,
    ST_WAIT = 3'b110
  } ecw_state_t;
endpackage : ecw_pkg

// *** rtl/ecw_sync.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to CLK; output moves only when stages two and three agree.
`timescale 1ns/1ps
module ecw_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;

  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      dout <= INIT;
    end
    else
    begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout <= (agree & s3_reg) | (~agree & dout);
    end
  end
endmodule : ecw_sync

// *** rtl/ecw_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides.
// Assumes the drain side may stall; in_ready falls when full so the source stalls too.
`timescale 1ns/1ps
module ecw_fifo #(
  parameter int unsigned WIDTH = ecw_pkg::FIFO_WIDTH,
  parameter int unsigned DEPTH = ecw_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Status
  output logic empty
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_wr;
  logic do_rd;

  // Count is one bit wider than the pointers so that full stays distinct from empty
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign empty = (count_reg == '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem_reg[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (do_rd)
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : ecw_fifo

// *** rtl/ecw_top.sv ***
// Write path of a serial EEPROM: two-wire slave front end, 64-byte page cache and the
// page-by-page programming engine that feeds array writes through a FIFO.
// Assumes SCL, SDA, straps and the supply-low flag are asynchronous to CLK (sampled here),
// and that the array sink accepts {address, data} words when ARR_READY is high.
`timescale 1ns/1ps
module ecw_top
  import ecw_pkg::*;
#(
  parameter int unsigned PAGE_PROG_CYCLES = ecw_pkg::PAGE_PROG_CYCLES_DFLT
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // Two-wire bus
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Chip-select straps
  input wire logic CHIP_SELECT_BIT0,
  input wire logic CHIP_SELECT_BIT1,
  input wire logic CHIP_SELECT_BIT2,
  // Supply monitor
  input wire logic SUPPLY_LOW,
  // Array write port
  output logic ARR_VALID,
  input wire logic ARR_READY,
  output logic [ecw_pkg::ADDR_W-1:0] ARR_ADDR,
  output logic [ecw_pkg::BYTE_W-1:0] ARR_DATA,
  // Status
  output logic BUSY,
  output logic STANDBY
);
  import ecw_pkg::*;

  localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(PAGE_PROG_CYCLES - 1);

  // Synchronised inputs
  logic scl_f;
  logic sda_f;
  logic [2:0] cs_f;
  logic supply_low_f;

  ecw_sync #(.WIDTH(2), .INIT(2'h3)) u_bus_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .din({SCL, SDA_IN}),
    .dout({scl_f, sda_f})
  );

  ecw_sync #(.WIDTH(4), .INIT(4'h0)) u_misc_sync (
    .clk(CLK),
    .rst_b(RST_B),
    .din({SUPPLY_LOW, CHIP_SELECT_BIT2, CHIP_SELECT_BIT1, CHIP_SELECT_BIT0}),
    .dout({supply_low_f, cs_f})
  );

  // State
  ecw_state_t state_reg;
  ecw_state_t state_next;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic [3:0] bit_cnt_reg;
  logic [BYTE_W-1:0] shift_reg;
  logic in_ack_reg;
  logic ack_drive_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [PTR_W-1:0] load_ptr_reg;
  logic [BYTE_W-1:0] cache_reg [CACHE_BYTES];
  logic [CACHE_BYTES-1:0] valid_reg;
  logic [PAGE_W-1:0] prog_page_reg;
  logic [PAGE_W-1:0] prog_byte_reg;
  logic [TIMER_W-1:0] timer_reg;

  // Bus events
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;
  logic ack_end;
  logic prog_active;
  logic ctrl_match;
  logic do_ack;
  logic data_store;

  assign scl_rise = scl_f && !scl_prev_reg;
  assign scl_fall = !scl_f && scl_prev_reg;
  // Start and stop detect
  // data change, clock high
  assign start_cond = scl_f && scl_prev_reg && sda_prev_reg && !sda_f;
  assign stop_cond = scl_f && scl_prev_reg && !sda_prev_reg && sda_f;
  assign byte_done = scl_fall && !in_ack_reg && (bit_cnt_reg == BITS_PER_BYTE);
  assign ack_end = scl_fall && in_ack_reg;
  assign prog_active = (state_reg == ST_PUSH) || (state_reg == ST_WAIT);
  assign ctrl_match = (shift_reg[7:4] == CTRL_CODE) && (shift_reg[3:1] == cs_f) && !shift_reg[0];
  assign do_ack = byte_done && (((state_reg == ST_CTRL) && ctrl_match) || (state_reg == ST_ADDR_HI)
                  || (state_reg == ST_ADDR_LO) || (state_reg == ST_DATA));
  assign data_store = byte_done && (state_reg == ST_DATA);

  // Programming engine decode
  logic [PTR_W-1:0] push_idx;
  logic [PAGE_BYTES-1:0] page_valid;
  logic page_loaded;
  logic supply_low_eff;
  logic push_valid;
  logic push_ready;
  logic push_advance;
  logic page_end;
  logic timer_done;
  logic fifo_empty;
  logic [ADDR_W-1:0] push_addr;
  logic [ADDR_W-1:0] page_base;

  assign push_idx = {prog_page_reg, prog_byte_reg};
  assign page_valid = valid_reg[{prog_page_reg, 3'h0} +: PAGE_BYTES];
  assign page_loaded = |page_valid;
  assign supply_low_eff = supply_low_f && !STANDBY;
  assign push_valid = (state_reg == ST_PUSH) && page_loaded && valid_reg[push_idx] && !supply_low_eff;
  assign push_advance = (state_reg == ST_PUSH) && (!page_loaded || !valid_reg[push_idx] || supply_low_eff
                        || push_ready);
  assign page_end = push_advance && (!page_loaded || (prog_byte_reg == LAST_BYTE));
  // cache page n to start page plus n
  assign page_base = {addr_reg[ADDR_W-1:3], 3'h0} + {ADDR_W'(prog_page_reg) << 3};
  assign push_addr = page_base + ADDR_W'(prog_byte_reg);
  assign timer_done = (timer_reg == '0) && fifo_empty;

  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (start_cond)
          state_next = ST_CTRL;
      end
      ST_CTRL, ST_ADDR_HI, ST_ADDR_LO:
      begin
        if (start_cond)
          state_next = ST_CTRL;
        else if (stop_cond)
          state_next = ST_IDLE;
        else if (byte_done && !do_ack)
          state_next = ST_IDLE;
        else if (byte_done && (state_reg == ST_CTRL))
          state_next = ST_ADDR_HI;
        else if (byte_done && (state_reg == ST_ADDR_HI))
          state_next = ST_ADDR_LO;
        else if (byte_done)
          state_next = ST_DATA;
      end
      ST_DATA:
      begin
        if (stop_cond && (|valid_reg))
          state_next = ST_PUSH;
        else if (stop_cond)
          state_next = ST_IDLE;
        else if (start_cond)
          state_next = ST_CTRL;
      end
      ST_PUSH:
      begin
        if (page_end)
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (timer_done && (prog_page_reg == LAST_PAGE))
          state_next = ST_IDLE;
        else if (timer_done)
          state_next = ST_PUSH;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Bus front end; everything is ignored while programming
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      state_reg <= ST_IDLE;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      in_ack_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      scl_prev_reg <= scl_f;
      sda_prev_reg <= sda_f;
      if (prog_active || start_cond || stop_cond)
      begin
        bit_cnt_reg <= 4'h0;
        in_ack_reg <= 1'b0;
        ack_drive_reg <= 1'b0;
      end
      else if (ack_end)
      begin
        in_ack_reg <= 1'b0;
        ack_drive_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
      end
      else if (byte_done)
      begin
        in_ack_reg <= 1'b1;
        ack_drive_reg <= do_ack;
      end
      else if (scl_rise && !in_ack_reg && (bit_cnt_reg != BITS_PER_BYTE))
      begin
        shift_reg <= {shift_reg[6:0], sda_f};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end
  end

  // Address pointer and cache load pointer
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      addr_reg <= 16'h0000;
      load_ptr_reg <= 6'h00;
      valid_reg <= 64'h0;
    end
    else if (byte_done && do_ack && (state_reg == ST_ADDR_HI))
      addr_reg <= {shift_reg, addr_reg[7:0]};
    else if (byte_done && do_ack && (state_reg == ST_ADDR_LO))
    begin
      addr_reg <= {addr_reg[15:8], shift_reg};
      // first byte into page 0 slot
      load_ptr_reg <= {3'h0, shift_reg[2:0]};
      valid_reg <= 64'h0;
    end
    else if (data_store)
    begin
      valid_reg[load_ptr_reg] <= 1'b1;
      // tail lands in page 0 head
      load_ptr_reg <= load_ptr_reg + 6'h01;
    end
  end

  // Cache storage
  // 64 bytes in arrival order
  always_ff @(posedge CLK)
  begin
    if (data_store)
      cache_reg[load_ptr_reg] <= shift_reg;
  end

  // Page walker and per-page timer
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      prog_page_reg <= 3'h0;
      prog_byte_reg <= 3'h0;
      timer_reg <= '0;
    end
    else if (state_reg == ST_DATA)
    begin
      prog_page_reg <= 3'h0;
      prog_byte_reg <= 3'h0;
      timer_reg <= '0;
    end
    else if (page_end)
    begin
      prog_byte_reg <= 3'h0;
      // full interval for any loaded page
      timer_reg <= page_loaded ? TIMER_LOAD : '0;
    end
    else if (push_advance)
      prog_byte_reg <= prog_byte_reg + 3'h1;
    else if ((state_reg == ST_WAIT) && (timer_reg != '0))
      timer_reg <= timer_reg - TIMER_W'(1);
    else if (timer_done && (state_reg == ST_WAIT))
      // next page after its own cycle
      prog_page_reg <= prog_page_reg + 3'h1;
  end

  // Array write buffer
  logic [FIFO_WIDTH-1:0] arr_word;

  ecw_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_arr_fifo (
    .clk(CLK),
    .rst_b(RST_B),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data({push_addr, cache_reg[push_idx]}),
    .out_valid(ARR_VALID),
    .out_ready(ARR_READY),
    .out_data(arr_word),
    .empty(fifo_empty)
  );

  assign ARR_ADDR = arr_word[FIFO_WIDTH-1:BYTE_W];
  assign ARR_DATA = arr_word[BYTE_W-1:0];
  assign SDA_OUT = 1'b0;
  assign SDA_OE = ack_drive_reg;
  assign BUSY = prog_active;
  assign STANDBY = (state_reg == ST_IDLE) && fifo_empty;

  // Checks
  property p_sda_low_only;
    @(posedge CLK) disable iff (!RST_B)
    SDA_OE |-> (SDA_OUT == 1'b0);
  endproperty
  a_sda_low_only: assert property (p_sda_low_only)
    else $error("data line driven high");

  property p_silent_prog;
    @(posedge CLK) disable iff (!RST_B)
    prog_active |=> !SDA_OE;
  endproperty
  a_silent_prog: assert property (p_silent_prog)
    else $error("acknowledge while programming");

  property p_stop_launch;
    @(posedge CLK) disable iff (!RST_B)
    (state_reg == ST_DATA && stop_cond && (|valid_reg)) |=> (state_reg == ST_PUSH) ##1 BUSY;
  endproperty
  a_stop_launch: assert property (p_stop_launch)
    else $error("stop did not launch programming");

  property p_first_slot;
    @(posedge CLK) disable iff (!RST_B)
    (state_reg == ST_ADDR_LO && byte_done && do_ack) |=> (load_ptr_reg == {3'h0, addr_reg[2:0]})
      && (valid_reg == 64'h0);
  endproperty
  a_first_slot: assert property (p_first_slot)
    else $error("first cache slot wrong");

  property p_wrap;
    @(posedge CLK) disable iff (!RST_B)
    (data_store && load_ptr_reg == 6'h3f) |=> (load_ptr_reg == 6'h00) && valid_reg[63];
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("cache pointer did not wrap");

  property p_supply_block;
    @(posedge CLK) disable iff (!RST_B)
    supply_low_eff |-> !push_valid;
  endproperty
  a_supply_block: assert property (p_supply_block)
    else $error("array write during supply low");

  property p_page_time;
    @(posedge CLK) disable iff (!RST_B)
    (page_end && page_loaded) |=> (timer_reg == TIMER_LOAD) && (state_reg == ST_WAIT);
  endproperty
  a_page_time: assert property (p_page_time)
    else $error("page interval not loaded");

  property p_only_loaded;
    @(posedge CLK) disable iff (!RST_B)
    push_valid |-> valid_reg[push_idx] && (push_addr[2:0] == prog_byte_reg);
  endproperty
  a_only_loaded: assert property (p_only_loaded)
    else $error("unloaded byte programmed");

  property p_cs_match;
    @(posedge CLK) disable iff (!RST_B)
    (byte_done && state_reg == ST_CTRL && shift_reg[3:1] != cs_f) |=> !SDA_OE && (state_reg == ST_IDLE);
  endproperty
  a_cs_match: assert property (p_cs_match)
    else $error("answered foreign select bits");

  property p_ack_ninth;
    @(posedge CLK) disable iff (!RST_B)
    (do_ack && !start_cond && !stop_cond) |=> SDA_OE;
  endproperty
  a_ack_ninth: assert property (p_ack_ninth)
    else $error("missing acknowledge");

  property p_next_page;
    @(posedge CLK) disable iff (!RST_B)
    (state_reg == ST_WAIT && timer_done && prog_page_reg != LAST_PAGE) |=> (state_reg == ST_PUSH)
      && (prog_page_reg == $past(prog_page_reg) + 3'h1);
  endproperty
  a_next_page: assert property (p_next_page)
    else $error("page walker did not advance");
endmodule : ecw_top

// *** tb/ecw_bus_master.sv ***
// Two-wire bus master model: drives the serial clock and pulls the data line low.
// Assumes the bench resolves the pulled-up data wire from both parties and returns it on sda.
`timescale 1ns/1ps
module ecw_bus_master (
  // Clock
  input wire logic clk,
  // Bus lines
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Clock stands high and data is released between frames
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  task automatic start_cond();
    sda_pull <= 1'b0;
    wait_clk(2);
    scl <= 1'b1;
    wait_clk(4);
    sda_pull <= 1'b1;
    wait_clk(4);
    scl <= 1'b0;
    wait_clk(2);
  endtask : start_cond

  task automatic stop_cond();
    sda_pull <= 1'b1;
    wait_clk(2);
    scl <= 1'b1;
    wait_clk(4);
    sda_pull <= 1'b0;
    wait_clk(8);
  endtask : stop_cond

  // data moves only with clock low
  task automatic bit_out(input logic b);
    sda_pull <= !b;
    wait_clk(2);
    scl <= 1'b1;
    wait_clk(4);
    scl <= 1'b0;
    wait_clk(2);
  endtask : bit_out

  // select bits ride in the control byte
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_out(b[i]);
    sda_pull <= 1'b0;
    // The slave pulls the line about five cycles after our clock falls; rising earlier
    // would make its acknowledge look like a start condition
    wait_clk(5);
    scl <= 1'b1;
    wait_clk(3);
    @(negedge clk);
    ack = !sda;
    wait_clk(1);
    scl <= 1'b0;
    // Stretch the low phase so the slave has let go before the next bit
    wait_clk(6);
  endtask : send_byte
endmodule : ecw_bus_master

// *** tb/testbench.sv ***
// Self-checking bench for the page-cache write path: bus master model, array sink, scenarios.
// Assumes the array sink may stall and that a short page interval stands in for 5 ms.
`timescale 1ns/1ps
module testbench;
  import ecw_pkg::*;
  localparam int PPC = 50;
  logic clk, rst_b, m_pull, scl, sda, sda_out, sda_oe, supply_low, arr_valid, arr_ready, busy, standby, stall;
  logic [2:0] cs;
  logic [1:0] cyc;
  logic [15:0] arr_addr;
  logic [7:0] arr_data;
  logic [23:0] got_q [$];
  int num_errors, samples_checked;

  // Pull-up: low only while some party pulls
  assign sda = !(m_pull || (sda_oe && !sda_out));

  ecw_bus_master bfm_u (.clk(clk), .scl(scl), .sda_pull(m_pull), .sda(sda));

  ecw_top #(.PAGE_PROG_CYCLES(PPC)) dut_u (
    .CLK(clk), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .CHIP_SELECT_BIT0(cs[0]), .CHIP_SELECT_BIT1(cs[1]), .CHIP_SELECT_BIT2(cs[2]),
    .SUPPLY_LOW(supply_low), .ARR_VALID(arr_valid), .ARR_READY(arr_ready),
    .ARR_ADDR(arr_addr), .ARR_DATA(arr_data), .BUSY(busy), .STANDBY(standby));

  always #25 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic out_of_time(input bit hit);
    if (hit)
    begin
      num_errors++;
      give_verdict();
    end
  endtask : out_of_time

  // Array sink: stalls three cycles in four when asked, records every accepted word
  always @(posedge clk)
  begin
    cyc <= cyc + 2'h1;
    arr_ready <= !stall || cyc == 2'h3;
    if (arr_valid === 1'b1 && arr_ready === 1'b1)
      got_q.push_back({arr_addr, arr_data});
    if (sda_oe === 1'b1)
      chk("data line drive", 0, 32'(sda_out));
  end

  // One write command; expectations come from a software copy of the cache
  task automatic do_write(input logic [15:0] addr, input int n, input logic [7:0] seed, input bit prog_ok,
                          input bit poll);
    logic [7:0] cache [64];
    bit vld [64];
    bit [7:0] pv;
    logic [23:0] exp_q [$];
    logic ack;
    int nb, i, pg;
    nb = 0;
    i = 0;
    pv = 8'h00;
    foreach (vld[s]) vld[s] = 1'b0;
    got_q.delete();
    bfm_u.start_cond();
    bfm_u.send_byte({CTRL_CODE, cs, 1'b0}, ack);
    chk("ack control", 1, 32'(ack));
    bfm_u.send_byte(addr[15:8], ack);
    chk("ack address high", 1, 32'(ack));
    bfm_u.send_byte(addr[7:0], ack);
    chk("ack address low", 1, 32'(ack));
    for (int k = 0; k < n; k++)
    begin
      cache[(addr[2:0] + k) % 64] = seed + 8'(k);
      vld[(addr[2:0] + k) % 64] = 1'b1;
      bfm_u.send_byte(seed + 8'(k), ack);
      chk("ack data", 1, 32'(ack));
    end
    bfm_u.stop_cond();
    for (int s = 0; s < 64; s++)
    begin
      pv[s / 8] = pv[s / 8] | vld[s];
      if (vld[s] && prog_ok)
        exp_q.push_back({16'({addr[15:3], 3'h0} + s), cache[s]});
    end
    pg = $countones(pv);
    while (busy !== 1'b1 && i < 20)
    begin
      @(posedge clk);
      i++;
    end
    chk("busy after stop", 1, 32'(busy));
    out_of_time(busy !== 1'b1);
    fork
      while (busy === 1'b1 && nb < 5000)
      begin
        @(posedge clk);
        nb++;
      end
      if (poll)
      begin
        bfm_u.start_cond();
        bfm_u.send_byte({CTRL_CODE, cs, 1'b0}, ack);
        chk("ack while busy", 0, 32'(ack));
        bfm_u.stop_cond();
      end
    join
    out_of_time(nb >= 5000);
    chk("busy length", 1, 32'(nb >= pg * PPC && nb <= pg * (PPC + 24) + 16));
    i = 0;
    while (standby !== 1'b1 && i < 10)
    begin
      @(posedge clk);
      i++;
    end
    chk("standby after write", 1, 32'(standby));
    out_of_time(standby !== 1'b1);
    repeat (4) @(posedge clk);
    chk("word count", 32'(exp_q.size()), 32'(got_q.size()));
    for (int w = 0; w < exp_q.size() && w < got_q.size(); w++)
      chk("array word", 32'(exp_q[w]), 32'(got_q[w]));
  endtask : do_write

  task automatic check_reset();
    chk("reset data enable", 0, 32'(sda_oe));
    chk("reset array valid", 0, 32'(arr_valid));
    chk("reset busy", 0, 32'(busy));
    chk("reset standby", 1, 32'(standby));
  endtask : check_reset

  // All select values, a wrong device code and a read request
  task automatic refuse_select();
    logic ack;
    for (int v = 0; v < 10; v++)
    begin
      bfm_u.start_cond();
      bfm_u.send_byte(v < 8 ? {CTRL_CODE, 3'(v), 1'b0} : (v == 8 ? {4'h5, cs, 1'b0} : {CTRL_CODE, cs, 1'b1}), ack);
      chk("ack select", 32'(v < 8 && 3'(v) == cs), 32'(ack));
      bfm_u.stop_cond();
    end
  endtask : refuse_select

  task automatic aligned_full();
    stall <= 1'b1;
    do_write(16'h0fe0, 64, 8'h10, 1'b1, 1'b1);
    stall <= 1'b0;
  endtask : aligned_full

  task automatic unaligned_wrap();
    do_write(16'h0123, 66, 8'h80, 1'b1, 1'b0);
  endtask : unaligned_wrap

  task automatic partial_page();
    cs <= 3'h2;
    repeat (8) @(posedge clk);
    do_write(16'h0345, 3, 8'hc0, 1'b1, 1'b0);
  endtask : partial_page

  task automatic supply_low_block();
    supply_low <= 1'b1;
    repeat (8) @(posedge clk);
    do_write(16'h0400, 9, 8'h33, 1'b0, 1'b0);
    supply_low <= 1'b0;
  endtask : supply_low_block

  // Stop right after the address: nothing to program
  task automatic early_stop();
    logic ack;
    int hits;
    hits = 0;
    bfm_u.start_cond();
    bfm_u.send_byte({CTRL_CODE, cs, 1'b0}, ack);
    bfm_u.send_byte(8'h01, ack);
    bfm_u.send_byte(8'h20, ack);
    bfm_u.stop_cond();
    repeat (40)
    begin
      @(posedge clk);
      hits += int'(busy !== 1'b0);
    end
    chk("busy without data", 0, 32'(hits));
    chk("standby without data", 1, 32'(standby));
  endtask : early_stop

  initial
  begin
    repeat (100000) @(posedge clk);
    out_of_time(1'b1);
  end

  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    cs = 3'h5;
    supply_low = 1'b0;
    stall = 1'b0;
    arr_ready = 1'b1;
    cyc = 2'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    check_reset();
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    refuse_select();
    aligned_full();
    unaligned_wrap();
    partial_page();
    supply_low_block();
    early_stop();
    give_verdict();
  end
endmodule : testbench
